// ---- adc_monitor_pkg.sv ----
// Constants, types and register map for the monitor select and fault status block.
// Assumes a 100 MHz system clock and a 32-bit APB register bus.
package adc_monitor_pkg;

    // Register indices; byte address is four times the index
    localparam logic [7:0] IDX_FAULT_FLAGS = 8'h01;
    localparam logic [7:0] IDX_GAIN_CTL    = 8'h03;
    localparam logic [7:0] IDX_REF_CTL     = 8'h05;
    localparam logic [7:0] IDX_EXC_CTL     = 8'h06;
    localparam logic [7:0] IDX_SYS_CTL     = 8'h09;
    localparam logic [7:0] IDX_DATA_FRAME  = 8'h12;

    // Field positions
    localparam int unsigned MON_SEL_LSB   = 0;
    localparam int unsigned PREPEND_BIT   = 3;
    localparam int unsigned GAIN_LSB      = 0;
    localparam int unsigned AMP_EN_LSB    = 3;
    localparam int unsigned REF_MON_LSB   = 0;
    localparam int unsigned RAIL_EN_BIT   = 0;
    localparam int unsigned POR_BIT       = 7;
    localparam int unsigned RDY_N_BIT     = 6;
    localparam int unsigned RAIL_LSB      = 2;
    localparam int unsigned REF_THIRD_BIT = 1;
    localparam int unsigned REF_LOW_BIT   = 0;
    localparam int unsigned FRAME_TAG_BIT = 24;

    // Values after reset
    localparam logic [7:0] SYS_CTL_RST     = 8'h00;
    localparam logic [7:0] GAIN_CTL_RST    = 8'h00;
    localparam logic [7:0] REF_CTL_RST     = 8'h00;
    localparam logic [7:0] EXC_CTL_RST     = 8'h00;
    localparam logic [7:0] FAULT_FLAGS_RST = 8'hC0;

    localparam logic [2:0] GAIN_ONE       = 3'h0;
    localparam int unsigned SUPPLY_DIVIDE = 4;

    // Start-up time before the ready flag goes low
    localparam int unsigned CLK_PERIOD_NS   = 10;
    localparam int unsigned STARTUP_TIME_NS = 2000;
    localparam int unsigned STARTUP_CYCLES  =
        (STARTUP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    typedef enum logic [2:0] {
        MON_OFF      = 3'b000,
        MON_MIDSCALE = 3'b001,
        MON_TEMP     = 3'b010,
        MON_AVDD     = 3'b011,
        MON_DVDD     = 3'b100,
        MON_BO_0P2   = 3'b101,
        MON_BO_1     = 3'b110,
        MON_BO_10    = 3'b111
    } monitor_sel_t;

    typedef enum logic [1:0] {
        BO_OFF = 2'b00,
        BO_0P2 = 2'b01,
        BO_1   = 2'b10,
        BO_10  = 2'b11
    } burnout_t;

    typedef enum logic {
        ST_INIT  = 1'b0,
        ST_READY = 1'b1
    } start_state_t;

    typedef struct packed {
        logic       inputs_disconnect;
        logic       midscale_short;
        logic       temp_sensor;
        logic       analog_supply_reading;
        logic       digital_supply_reading;
        logic [2:0] gain_eff;
        logic [1:0] amp_enable;
        burnout_t   burnout_current;
        logic       burnout_source_p;
        logic       burnout_sink_n;
    } route_t;

    typedef struct packed {
        logic        with_flags;
        logic [23:0] bytes;
    } frame_t;

endpackage

// ---- adc_monitor_select_fault_status.sv ----
// Monitor input selection, gain forcing and the fault status byte with its APB slave.
// Assumes rail and reference comparator levels and data_ready_n are synchronous to clk.
//
// The APB slave port was left to the implementer.
`timescale 1ns/1ns
`default_nettype none

// Operation
// - Selector 010 routes temperature sensor in
// - Temperature: inputs cut, selected gain kept
// - 011 analog, 100 digital supply, divided
// - Supply monitor: inputs cut, gain one
// - 101, 110, 111 pick burn-out currents
// - Source into positive, sink from negative
// - Flags readable, optionally prepended to data
// - Read returns last completed conversion flags
// - Power-on flag set, host clears it
// - Bit 6 low means started and ready
// - Bits 5 to 2 hold rail flags
// - Rail monitors gated by their enable
// - Rail faults latched, updated at end
// - Reference flags when monitor enable nonzero
// - Reference flags update on ready fall
// - Selector 001 shorts input to mid-scale
module adc_monitor_select_fault_status
    import adc_monitor_pkg::*;
#(
    parameter int unsigned ADDR_W = 8
) (
    input  wire logic              clk,
    input  wire logic              rst_n,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    input  wire logic [3:0]        pstrb,
    output logic [31:0]            prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire logic              data_ready_n,
    input  wire logic [15:0]       conv_data,
    input  wire logic [3:0]        rail_fault_raw,
    input  wire logic              ref_low_raw,
    input  wire logic              ref_third_raw,
    output route_t                 route,
    output frame_t                 data_frame
);

    ////////////////////////////////////////////////////////////////////////////
    // Decode helpers

    function automatic logic [7:0] reg_index(input logic [ADDR_W-1:0] a);
        return 8'(a >> 2);
    endfunction

    function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
        logic [7:0] i;
        i = reg_index(a);
        return (a[1:0] == 2'b00) &&
               (i == IDX_FAULT_FLAGS || i == IDX_GAIN_CTL || i == IDX_REF_CTL ||
                i == IDX_EXC_CTL || i == IDX_SYS_CTL || i == IDX_DATA_FRAME);
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Declarations

    start_state_t state_reg;
    logic [15:0]  startup_cnt_reg;
    logic [7:0]   sys_ctl_reg;
    logic [7:0]   gain_ctl_reg;
    logic [7:0]   ref_ctl_reg;
    logic [7:0]   exc_ctl_reg;
    logic         por_flag_reg;
    logic [3:0]   rail_flags_reg;
    logic [3:0]   rail_acc_reg;
    logic [1:0]   ref_flags_reg;
    logic [1:0]   ref_acc_reg;
    logic         data_ready_n_prev_reg;
    logic [31:0]  prdata_reg;
    frame_t       frame_reg;
    logic         conv_end;
    logic         acc_wr;
    logic         setup_rd;
    logic         rail_en;
    logic         ref_en;
    logic [3:0]   rail_live;
    logic [1:0]   ref_live;
    logic [3:0]   rail_flags_next;
    logic [1:0]   ref_flags_next;
    logic [7:0]   fault_flags;
    logic [7:0]   fault_flags_next;
    monitor_sel_t mon_sel;

    assign mon_sel   = monitor_sel_t'(sys_ctl_reg[MON_SEL_LSB +: 3]);
    assign rail_en   = exc_ctl_reg[RAIL_EN_BIT];
    assign ref_en    = |ref_ctl_reg[REF_MON_LSB +: 2];
    assign conv_end  = data_ready_n_prev_reg & ~data_ready_n;
    assign rail_live = rail_fault_raw & {4{rail_en}};
    assign ref_live  = {ref_third_raw, ref_low_raw} & {2{ref_en}};

    ////////////////////////////////////////////////////////////////////////////
    // Start-up sequencing

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg       <= ST_INIT;
            startup_cnt_reg <= 16'h0000;
        end else begin
            case (state_reg)
                ST_INIT: begin
                    startup_cnt_reg <= startup_cnt_reg + 16'h0001;
                    if (startup_cnt_reg == 16'(STARTUP_CYCLES - 1)) begin
                        state_reg <= ST_READY;
                    end
                end
                ST_READY: state_reg <= ST_READY;
                default:  state_reg <= ST_INIT;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // APB slave

    assign pready   = (state_reg == ST_READY);
    assign pslverr  = psel & penable & pready & ~is_mapped(paddr);
    assign acc_wr   = psel & penable & pready & pwrite & is_mapped(paddr) & pstrb[0];
    assign setup_rd = psel & ~penable & ~pwrite;
    assign prdata   = prdata_reg;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sys_ctl_reg  <= SYS_CTL_RST;
            gain_ctl_reg <= GAIN_CTL_RST;
            ref_ctl_reg  <= REF_CTL_RST;
            exc_ctl_reg  <= EXC_CTL_RST;
        end else if (acc_wr) begin
            case (reg_index(paddr))
                IDX_SYS_CTL:  sys_ctl_reg  <= pwdata[7:0];
                IDX_GAIN_CTL: gain_ctl_reg <= pwdata[7:0];
                IDX_REF_CTL:  ref_ctl_reg  <= pwdata[7:0];
                IDX_EXC_CTL:  exc_ctl_reg  <= pwdata[7:0];
                default: ;
            endcase
        end
    end

    // Read data captured in the setup cycle, shown in the access cycle
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            prdata_reg <= 32'h0000_0000;
        end else if (setup_rd) begin
            case (reg_index(paddr))
                IDX_FAULT_FLAGS: prdata_reg <= {24'h00_0000, fault_flags};
                IDX_SYS_CTL:     prdata_reg <= {24'h00_0000, sys_ctl_reg};
                IDX_GAIN_CTL:    prdata_reg <= {24'h00_0000, gain_ctl_reg};
                IDX_REF_CTL:     prdata_reg <= {24'h00_0000, ref_ctl_reg};
                IDX_EXC_CTL:     prdata_reg <= {24'h00_0000, exc_ctl_reg};
                IDX_DATA_FRAME:  prdata_reg <= {7'h00, frame_reg};
                default:         prdata_reg <= 32'h0000_0000;
            endcase
            if (paddr[1:0] != 2'b00) begin
                prdata_reg <= 32'h0000_0000;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Power-on flag

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            por_flag_reg <= 1'b1;
        end else if (acc_wr && reg_index(paddr) == IDX_FAULT_FLAGS && !pwdata[POR_BIT]) begin
            por_flag_reg <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Fault latches, flags move only at the end of a conversion

    always_comb begin
        rail_flags_next = rail_acc_reg | rail_live;
        ref_flags_next  = ref_acc_reg | ref_live;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            data_ready_n_prev_reg <= 1'b1;
        end else begin
            data_ready_n_prev_reg <= data_ready_n;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rail_acc_reg   <= 4'h0;
            rail_flags_reg <= 4'h0;
        end else if (conv_end) begin
            rail_flags_reg <= rail_flags_next;
            rail_acc_reg   <= 4'h0;
        end else begin
            rail_acc_reg   <= rail_flags_next;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ref_acc_reg   <= 2'h0;
            ref_flags_reg <= 2'h0;
        end else if (conv_end) begin
            ref_flags_reg <= ref_flags_next;
            ref_acc_reg   <= 2'h0;
        end else begin
            ref_acc_reg   <= ref_flags_next;
        end
    end

    // Status byte: power-on, ready (low), four rail flags, two reference flags
    always_comb begin
        fault_flags                            = 8'h00;
        fault_flags[POR_BIT]                   = por_flag_reg;
        fault_flags[RDY_N_BIT]                 = (state_reg != ST_READY);
        fault_flags[RAIL_LSB +: 4]             = rail_flags_reg;
        fault_flags[REF_LOW_BIT]               = ref_flags_reg[0];
        fault_flags[REF_THIRD_BIT]             = ref_flags_reg[1];
        fault_flags_next                       = fault_flags;
        fault_flags_next[RAIL_LSB +: 4]        = rail_flags_next;
        fault_flags_next[REF_LOW_BIT]          = ref_flags_next[0];
        fault_flags_next[REF_THIRD_BIT]        = ref_flags_next[1];
    end

    ////////////////////////////////////////////////////////////////////////////
    // Conversion frame with optional leading status byte

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            frame_reg <= '0;
        end else if (conv_end) begin
            frame_reg.with_flags <= sys_ctl_reg[PREPEND_BIT];
            if (sys_ctl_reg[PREPEND_BIT]) begin
                frame_reg.bytes <= {fault_flags_next, conv_data};
            end else begin
                frame_reg.bytes <= {8'h00, conv_data};
            end
        end
    end

    assign data_frame = frame_reg;

    ////////////////////////////////////////////////////////////////////////////
    // Monitor routing

    always_comb begin
        route            = '0;
        route.gain_eff   = gain_ctl_reg[GAIN_LSB +: 3];
        route.amp_enable = gain_ctl_reg[AMP_EN_LSB +: 2];
        route.burnout_current = BO_OFF;
        case (mon_sel)
            MON_OFF: ;
            MON_MIDSCALE: begin
                route.midscale_short    = 1'b1;
                route.inputs_disconnect = 1'b1;
            end
            MON_TEMP: begin
                // Gain kept as programmed; host limits it to four
                route.temp_sensor       = 1'b1;
                route.inputs_disconnect = 1'b1;
            end
            MON_AVDD: begin
                route.analog_supply_reading = 1'b1;
                route.inputs_disconnect     = 1'b1;
                route.gain_eff              = GAIN_ONE;
            end
            MON_DVDD: begin
                route.digital_supply_reading = 1'b1;
                route.inputs_disconnect      = 1'b1;
                route.gain_eff               = GAIN_ONE;
            end
            MON_BO_0P2: route.burnout_current = BO_0P2;
            MON_BO_1:   route.burnout_current = BO_1;
            MON_BO_10:  route.burnout_current = BO_10;
            default: ;
        endcase
        route.burnout_source_p = (route.burnout_current != BO_OFF);
        route.burnout_sink_n   = (route.burnout_current != BO_OFF);
    end

    ////////////////////////////////////////////////////////////////////////////
    // Assertions

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    a_temp_route: assert property (mon_sel == MON_TEMP |->
        route.temp_sensor && !route.analog_supply_reading && !route.midscale_short)
        else $error("temperature sensor not routed");

    a_temp_gain_kept: assert property (mon_sel == MON_TEMP |->
        route.inputs_disconnect && route.gain_eff == gain_ctl_reg[2:0])
        else $error("temperature path gain or disconnect wrong");

    a_supply_select: assert property (
        route.analog_supply_reading == (mon_sel == MON_AVDD) &&
        route.digital_supply_reading == (mon_sel == MON_DVDD))
        else $error("supply monitor selection wrong");

    a_supply_gain_one: assert property ((mon_sel == MON_AVDD || mon_sel == MON_DVDD) |->
        route.gain_eff == GAIN_ONE && route.inputs_disconnect &&
        route.amp_enable == gain_ctl_reg[4:3])
        else $error("supply monitor gain not forced to one");

    a_burnout_level: assert property (
        route.burnout_current == ((mon_sel == MON_BO_0P2) ? BO_0P2 :
                                  (mon_sel == MON_BO_1)   ? BO_1 :
                                  (mon_sel == MON_BO_10)  ? BO_10 : BO_OFF))
        else $error("burn-out current level wrong");

    a_burnout_dir: assert property (
        (mon_sel == MON_BO_0P2 || mon_sel == MON_BO_1 || mon_sel == MON_BO_10) |->
        route.burnout_source_p && route.burnout_sink_n && !route.inputs_disconnect)
        else $error("burn-out sources not applied to inputs");

    a_midscale_short: assert property (
        route.midscale_short == (mon_sel == MON_MIDSCALE))
        else $error("mid-scale short wrong");

    a_por_held: assert property (por_flag_reg && !acc_wr |=> por_flag_reg)
        else $error("power-on flag lost without a write");

    a_ready_bus: assert property (state_reg == ST_INIT |->
        !pready && fault_flags[RDY_N_BIT])
        else $error("ready shown during start-up");

    a_rail_hold: assert property (!conv_end |=>
        $stable(rail_flags_reg) && $stable(ref_flags_reg))
        else $error("fault flags moved between conversions");

    a_rail_latch: assert property (conv_end |=>
        rail_flags_reg == $past(rail_acc_reg | (rail_fault_raw & {4{rail_en}})))
        else $error("rail flags not latched at conversion end");

    a_ref_update: assert property ($fell(data_ready_n) |=>
        ref_flags_reg == ($past(ref_acc_reg) |
                          ($past({ref_third_raw, ref_low_raw}) & {2{$past(ref_en)}})))
        else $error("reference flags not updated on ready fall");

    a_flags_read: assert property (setup_rd && paddr == ADDR_W'(4 * IDX_FAULT_FLAGS)
        |=> prdata == {24'h00_0000, $past(fault_flags)})
        else $error("status read returned wrong byte");

    a_flags_ro: assert property (acc_wr && !conv_end |=>
        fault_flags[6:0] == $past(fault_flags[6:0]))
        else $error("write disturbed read-only flags");

    a_prepend_frame: assert property (conv_end && sys_ctl_reg[PREPEND_BIT] |=>
        data_frame.bytes[23:16] == {$past(fault_flags[7:6]), fault_flags[5:0]} &&
        data_frame.bytes[15:0] == $past(conv_data) && data_frame.with_flags)
        else $error("status byte not prepended");

    c_temp_sel:   cover property (mon_sel == MON_TEMP && conv_end);
    c_rail_fault: cover property (conv_end && |rail_live);
    c_por_clear:  cover property (por_flag_reg ##1 !por_flag_reg);
    c_prepend:    cover property (conv_end && sys_ctl_reg[PREPEND_BIT]);

endmodule

`default_nettype wire

// ---- conv_model.sv ----
// Conversion source model: data-ready pulses and conversion results.
// Assumes requests arrive as one-cycle go pulses synchronous to clk.
`timescale 1ns/1ns
`default_nettype none
module conv_model (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        go,
    input  wire logic [15:0] din,
    output logic             data_ready_n,
    output logic [15:0]      conv_data
);
    logic [15:0] held_reg;

    ////////////////////////////////////////
    // Ready low one cycle, then high again before the next fall
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            data_ready_n <= 1'b1;
            held_reg     <= 16'h0000;
        end else begin
            data_ready_n <= !(go && data_ready_n);
            held_reg     <= din;
        end
    end

    // Data only valid while ready is low
    assign conv_data = data_ready_n ? ~held_reg : held_reg;
endmodule
`default_nettype wire

// ---- tb_top.sv ----
// Self-checking bench for the monitor select and fault status block.
// Assumes the APB slave, the conversion source model and a 100 MHz clock.
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    import adc_monitor_pkg::*;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        go = 1'b0;
    logic [15:0] cdata = 16'h0000;
    logic        data_ready_n;
    logic [15:0] conv_data;
    logic [3:0]  rail = 4'h0;
    logic        rlow = 1'b0;
    logic        rthird = 1'b0;
    route_t      route;
    frame_t      frame;
    int          n_errors = 0;
    int          samples_checked = 0;
    int          cyc = 0;
    logic [31:0] rd;
    logic        er;
    logic [2:0]  g;
    logic [1:0]  m;
    logic [3:0]  f;
    logic [1:0]  r2;
    logic [15:0] d;

    always #5 clk = ~clk;

    adc_monitor_select_fault_status u_adc_monitor_select_fault_status (
        .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .data_ready_n(data_ready_n), .conv_data(conv_data),
        .rail_fault_raw(rail), .ref_low_raw(rlow), .ref_third_raw(rthird),
        .route(route), .data_frame(frame));

    conv_model u_conv_model (.clk(clk), .rst_n(rst_n), .go(go), .din(cdata),
        .data_ready_n(data_ready_n), .conv_data(conv_data));

    ////////////////////////////////////////
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    always @(posedge clk) begin
        cyc++;
        if (cyc == 6000) begin
            n_errors++;
            tally_and_finish();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    function automatic logic [7:0] ba(input logic [7:0] i);
        return {i[5:0], 2'b00};
    endfunction

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic conv(input logic [15:0] v);
        @(posedge clk);
        go <= 1'b1;
        cdata <= v;
        @(posedge clk);
        go <= 1'b0;
        repeat (4) @(posedge clk);
    endtask

    function automatic route_t exp_route(input logic [2:0] s, input logic [2:0] gn,
                                         input logic [1:0] am);
        route_t r;
        r = '0;
        r.inputs_disconnect = (s >= 3'h1) && (s <= 3'h4);
        r.midscale_short = (s == 3'h1);
        r.temp_sensor = (s == 3'h2);
        r.analog_supply_reading = (s == 3'h3);
        r.digital_supply_reading = (s == 3'h4);
        r.gain_eff = (s == 3'h3 || s == 3'h4) ? GAIN_ONE : gn;
        r.amp_enable = am;
        r.burnout_current = (s >= 3'h5) ? burnout_t'(s[1:0]) : BO_OFF;
        r.burnout_source_p = (s >= 3'h5);
        r.burnout_sink_n = (s >= 3'h5);
        return r;
    endfunction

    ////////////////////////////////////////
    initial begin
        rd = $urandom(61674);
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        chk({31'h0, pready}, 32'h0000_0000);
        repeat (STARTUP_CYCLES + 5) @(posedge clk);
        apb(1'b0, ba(IDX_FAULT_FLAGS), 32'h0000_0000);
        chk(rd, 32'h0000_0080);
        apb(1'b1, ba(IDX_FAULT_FLAGS), 32'h0000_00FF);
        apb(1'b0, ba(IDX_FAULT_FLAGS), 32'h0000_0000);
        chk(rd, 32'h0000_0080);
        apb(1'b1, ba(IDX_FAULT_FLAGS), 32'h0000_0000);
        apb(1'b0, ba(IDX_FAULT_FLAGS), 32'h0000_0000);
        chk(rd, 32'h0000_0000);
        $display("test power-on flag done");
        for (int s = 0; s < 8; s++) begin
            g = (s == 2) ? 3'($urandom_range(2)) : 3'($urandom_range(7));
            m = 2'($urandom_range(3));
            apb(1'b1, ba(IDX_GAIN_CTL), {27'h0, m, g});
            apb(1'b1, ba(IDX_SYS_CTL), 32'(s));
            @(posedge clk);
            chk(32'(route), 32'(exp_route(3'(s), g, m)));
        end
        $display("test monitor routing done");
        apb(1'b1, ba(IDX_SYS_CTL), 32'h0000_0000);
        apb(1'b1, ba(IDX_EXC_CTL), 32'h0000_0001);
        f = 4'($urandom_range(15, 1));
        @(posedge clk);
        rail <= f;
        @(posedge clk);
        rail <= 4'h0;
        apb(1'b0, ba(IDX_FAULT_FLAGS), 32'h0000_0000);
        chk(rd, 32'h0000_0000);
        conv(16'($urandom));
        apb(1'b0, ba(IDX_FAULT_FLAGS), 32'h0000_0000);
        chk(rd, {26'h0, f, 2'b00});
        conv(16'($urandom));
        apb(1'b0, ba(IDX_FAULT_FLAGS), 32'h0000_0000);
        chk(rd, 32'h0000_0000);
        apb(1'b1, ba(IDX_EXC_CTL), 32'h0000_0000);
        rail <= 4'hF;
        conv(16'($urandom));
        rail <= 4'h0;
        apb(1'b0, ba(IDX_FAULT_FLAGS), 32'h0000_0000);
        chk(rd, 32'h0000_0000);
        $display("test rail flags done");
        apb(1'b1, ba(IDX_REF_CTL), 32'($urandom_range(3, 1)));
        r2 = 2'($urandom_range(3, 1));
        rlow <= r2[0];
        rthird <= r2[1];
        apb(1'b0, ba(IDX_FAULT_FLAGS), 32'h0000_0000);
        chk(rd, 32'h0000_0000);
        conv(16'($urandom));
        rlow <= 1'b0;
        rthird <= 1'b0;
        apb(1'b0, ba(IDX_FAULT_FLAGS), 32'h0000_0000);
        chk(rd, {30'h0, r2});
        apb(1'b1, ba(IDX_REF_CTL), 32'h0000_0000);
        conv(16'($urandom)); // Flushes faults gathered while enabled
        rlow <= 1'b1;
        conv(16'($urandom));
        rlow <= 1'b0;
        apb(1'b0, ba(IDX_FAULT_FLAGS), 32'h0000_0000);
        chk(rd, 32'h0000_0000);
        $display("test reference flags done");
        apb(1'b1, ba(IDX_EXC_CTL), 32'h0000_0001);
        apb(1'b1, ba(IDX_SYS_CTL), 32'h0000_0008);
        d = 16'($urandom);
        rail <= f;
        conv(d);
        chk({7'h00, frame}, {8'h01, 2'b00, f, 2'b00, d});
        rail <= 4'h0;
        apb(1'b0, ba(IDX_DATA_FRAME), 32'h0000_0000);
        chk(rd, {8'h01, 2'b00, f, 2'b00, d});
        apb(1'b1, ba(IDX_SYS_CTL), 32'h0000_0000);
        d = 16'($urandom);
        conv(d);
        chk({7'h00, frame}, {16'h0000, d});
        apb(1'b0, ba(IDX_DATA_FRAME), 32'h0000_0000);
        chk(rd, {16'h0000, d});
        $display("test data frame done");
        apb(1'b0, 8'h08, 32'h0000_0000);
        chk({31'h0, er}, 32'h0000_0001);
        chk(rd, 32'h0000_0000);
        apb(1'b0, 8'h05, 32'h0000_0000);
        chk({31'h0, er}, 32'h0000_0001);
        $display("test unmapped access done");
        tally_and_finish();
    end
endmodule
`default_nettype wire
